// ---- rtl/hpd_driver_seq.sv ----
`default_nettype none
`include "hpd_consts.svh"
module hpd_driver_seq (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // timing
  input wire logic msTick,
  input wire logic [11:0] delayMs,
  input wire logic [2:0] stepMs,
  input wire logic rampEn,
  // control
  input wire logic powerReq,
  input wire logic autoShut,
  input wire logic shortNow,
  // status
  output logic powered,
  output logic [5:0] atten,
  output logic shortFlag
);
  hpd_pkg::hpd_drv_state_e state;
  logic reqQ;
  logic [11:0] msCnt;
  logic [2:0] stepCnt;
  logic killNow;
  logic reqRise;

  assign killNow = shortNow && autoShut && (state != hpd_pkg::DRV_OFF);
  assign reqRise = powerReq && !reqQ;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqQ <= 1'b0;
    end else begin
      reqQ <= powerReq;
    end
  end

  // only a fresh off-to-on request starts a driver, so a shutdown one stays dark
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= hpd_pkg::DRV_OFF;
    end else if (!powerReq || killNow) begin // R11
      state <= hpd_pkg::DRV_OFF;
    end else begin
      unique case (state)
        hpd_pkg::DRV_OFF: begin
          if (reqRise && !shortFlag) begin
            state <= hpd_pkg::DRV_DELAY;
          end
        end
        hpd_pkg::DRV_DELAY: begin
          if (msCnt >= delayMs) begin // R2
            state <= rampEn ? hpd_pkg::DRV_RAMP : hpd_pkg::DRV_ON;
          end
        end
        hpd_pkg::DRV_RAMP: begin
          if (atten == 6'h00) begin
            state <= hpd_pkg::DRV_ON;
          end
        end
        hpd_pkg::DRV_ON: begin
          state <= hpd_pkg::DRV_ON;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      msCnt <= 12'h000;
    end else if (state != hpd_pkg::DRV_DELAY) begin
      msCnt <= 12'h000; // R16
    end else if (msTick && msCnt != 12'hfff) begin
      msCnt <= msCnt + 12'h001; // R16
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stepCnt <= 3'h0;
      atten <= `HPD_ATTEN_MAX;
    end else if (state != hpd_pkg::DRV_RAMP) begin
      stepCnt <= 3'h0;
      if (state != hpd_pkg::DRV_ON) begin
        atten <= rampEn ? `HPD_ATTEN_MAX : 6'h00; // R4
      end
    end else if (msTick) begin
      if (stepCnt >= stepMs) begin
        stepCnt <= 3'h0;
        if (atten != 6'h00) begin
          atten <= atten - 6'h01; // R4
        end
      end else begin
        stepCnt <= stepCnt + 3'h1; // R16
      end
    end
  end

  // set wins; the flag only clears while software holds the driver off
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shortFlag <= 1'b0;
    end else if (killNow) begin
      shortFlag <= 1'b1; // R11
    end else if (!powerReq) begin
      shortFlag <= 1'b0; // R11
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      powered <= 1'b0;
    end else begin
      powered <= (state == hpd_pkg::DRV_RAMP) || (state == hpd_pkg::DRV_ON);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/hpd_power_detect.sv ----
// How it works
// R1: software writes the output configuration first, and the block picks its power-up scheme from it.
// R2: each driver waits a programmed delay, from none up to four seconds, before it powers up.
// R3: a powered-down driver pin sits high impedance, weakly at the common-mode level, or weakly at half supply.
// R4: with the ramp option on (its reset value) a driver starts fully attenuated and steps down to its gain; here CFG_SE_CM never ramps drivers 2 and 3.
// R5: each driver has a level setting of up to nine decibels for full-scale trimming, not for volume.
// R6: the two headphone drivers can take the converter outputs directly, bypassing volume and mixing.
// R7: after reset every unselected analog input is left high impedance.
// R8: per-input bits weakly hold unselected inputs at the common-mode level, and software drops them on selection.
// R9: the microphone bias field picks 2 V, 2.5 V, the analog supply, or off.
// R10: a shorted driver is current limited and the live protection state is readable.
// R11: with automatic shutdown a shorted driver is turned off and its flag clears only after an off then on command; here it clears at the off command.
// R12: the jack is watched for a plug, the headset type is classified, and the result is readable.
// R13: with ac-coupled outputs mono and stereo headphones are not told apart.
// R14: software should use the highest bias and the lowest two common-mode levels for detection.
// R15: the four drivers work as differential pairs, single-ended, with reference drivers, bridged, or mixed.
// R16: delay and ramp steps are counted in millisecond ticks, restarting on each power-up request.
`default_nettype none
`include "hpd_consts.svh"
module hpd_power_detect #(
  parameter int MS_CYCLES = `HPD_MS_NS / `HPD_CLK_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // analog sense, asynchronous
  input wire logic [3:0] shortSense,
  input wire logic plugSense,
  input wire logic micSense,
  input wire logic monoSense,
  // preamplifier selection, same clock
  input wire logic [3:0] leftInputSelected,
  input wire logic [3:0] rightInputSelected,
  // driver controls
  output hpd_pkg::hpd_drv_s [3:0] drvStatus,
  output logic leftDirectConverterPath,
  output logic rightDirectConverterPath,
  output hpd_pkg::hpd_cfg_e configMode,
  // input and bias controls
  output logic [3:0] leftInputHold,
  output logic [3:0] rightInputHold,
  output hpd_pkg::hpd_bias_e microphoneBiasOutput
);
  // register storage
  logic [7:0] outputConfigType;
  logic [7:0] leftInputHoldControl;
  logic [7:0] rightInputHoldControl;
  logic [7:0] micBiasControl;
  logic [7:0] driverGainRampControl;
  logic [7:0] driverPowerupDelayAndIdleState;
  logic [7:0] driverLevel01;
  logic [7:0] driverLevel23;
  logic [7:0] driverPower;
  logic [7:0] jackDetectConfigA;
  logic [7:0] jackDetectConfigB;
  logic [3:0] headsetScratch;

  // synchronised sense levels
  logic [6:0] senseSync;
  logic [3:0] shortNow;
  logic plugNow;
  logic micNow;
  logic monoNow;

  // timing
  logic [15:0] divCnt;
  logic msTick;
  logic [11:0] delayMs;

  // driver sequencing
  hpd_pkg::hpd_cfg_e cfgMode;
  logic [3:0] drvReq;
  logic [3:0] drvRampEn;
  logic [3:0] drvPowered;
  logic [5:0] drvAtten [4];
  logic [3:0] drvShortFlag;
  logic [3:0] drvLevel [4];
  hpd_pkg::hpd_pin_e idleMode;

  // jack detection
  hpd_pkg::hpd_hs_e rawType;
  hpd_pkg::hpd_hs_e candType;
  hpd_pkg::hpd_hs_e headsetType;
  logic [2:0] debCnt;

  hpd_sync2 #(
    .WIDTH(7)
  ) u_sense_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn({monoSense, micSense, plugSense, shortSense}),
    .syncOut(senseSync)
  );

  assign shortNow = senseSync[3:0];
  assign plugNow = senseSync[4] ^ jackDetectConfigB[`HPD_JACKB_PLUG_INV];
  assign micNow = senseSync[5] ^ jackDetectConfigB[`HPD_JACKB_MIC_INV];
  assign monoNow = senseSync[6] ^ jackDetectConfigB[`HPD_JACKB_MONO_INV];

  // register writes; reset values leave inputs floating and the ramp on
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      outputConfigType <= `HPD_RST_ZERO;
      leftInputHoldControl <= `HPD_RST_ZERO; // R7
      rightInputHoldControl <= `HPD_RST_ZERO; // R7
      micBiasControl <= `HPD_RST_ZERO;
      driverGainRampControl <= `HPD_RST_RAMP; // R4
      driverPowerupDelayAndIdleState <= `HPD_RST_ZERO;
      driverLevel01 <= `HPD_RST_ZERO;
      driverLevel23 <= `HPD_RST_ZERO;
      driverPower <= `HPD_RST_ZERO;
      jackDetectConfigA <= `HPD_RST_ZERO;
      jackDetectConfigB <= `HPD_RST_ZERO;
      headsetScratch <= 4'h0;
    end else if (regWrite) begin
      case (regAddr)
        `HPD_ADDR_HS_RESULT: headsetScratch <= regWdata[3:0];
        `HPD_ADDR_OUT_CFG: outputConfigType <= regWdata; // R1
        `HPD_ADDR_HOLD_L: leftInputHoldControl <= regWdata; // R8
        `HPD_ADDR_HOLD_R: rightInputHoldControl <= regWdata; // R8
        `HPD_ADDR_MIC_BIAS: micBiasControl <= regWdata; // R9
        `HPD_ADDR_RAMP: driverGainRampControl <= regWdata; // R4
        `HPD_ADDR_DELAY_IDLE: driverPowerupDelayAndIdleState <= regWdata; // R2
        `HPD_ADDR_LEVEL_01: driverLevel01 <= regWdata; // R5
        `HPD_ADDR_LEVEL_23: driverLevel23 <= regWdata; // R5
        `HPD_ADDR_POWER: driverPower <= regWdata;
        `HPD_ADDR_JACK_A: jackDetectConfigA <= regWdata; // R12
        `HPD_ADDR_JACK_B: jackDetectConfigB <= regWdata; // R12
        default: begin
        end
      endcase
    end
  end

  // register reads; unmapped offsets read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `HPD_ADDR_HS_RESULT: regRdata <= {plugNow, 1'b0, headsetType, headsetScratch}; // R12
        `HPD_ADDR_OUT_CFG: regRdata <= outputConfigType;
        `HPD_ADDR_HOLD_L: regRdata <= leftInputHoldControl;
        `HPD_ADDR_HOLD_R: regRdata <= rightInputHoldControl;
        `HPD_ADDR_MIC_BIAS: regRdata <= micBiasControl;
        `HPD_ADDR_RAMP: regRdata <= driverGainRampControl;
        `HPD_ADDR_DELAY_IDLE: regRdata <= driverPowerupDelayAndIdleState;
        `HPD_ADDR_LEVEL_01: regRdata <= driverLevel01;
        `HPD_ADDR_LEVEL_23: regRdata <= driverLevel23;
        `HPD_ADDR_POWER: regRdata <= driverPower;
        `HPD_ADDR_SHORT: regRdata <= {drvShortFlag, shortNow}; // R10
        `HPD_ADDR_JACK_A: regRdata <= jackDetectConfigA;
        `HPD_ADDR_JACK_B: regRdata <= jackDetectConfigB;
        default: regRdata <= 8'h00;
      endcase
    end
  end

  // millisecond enable; long delays are counted in ms to keep counters small
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt <= 16'h0000;
      msTick <= 1'b0;
    end else if (divCnt >= 16'(MS_CYCLES - 1)) begin
      divCnt <= 16'h0000;
      msTick <= 1'b1; // R16
    end else begin
      divCnt <= divCnt + 16'h0001;
      msTick <= 1'b0;
    end
  end

  // delay code to milliseconds, top code is the longest delay
  always_comb begin
    unique case (driverPowerupDelayAndIdleState[`HPD_DELAY_LSB +: 4])
      4'h0: delayMs = 12'h000; // R2
      4'h1: delayMs = 12'h001;
      4'h2: delayMs = 12'h002;
      4'h3: delayMs = 12'h005;
      4'h4: delayMs = 12'h00a;
      4'h5: delayMs = 12'h014;
      4'h6: delayMs = 12'h032;
      4'h7: delayMs = 12'h064;
      4'h8: delayMs = 12'h0c8;
      4'h9: delayMs = 12'h190;
      4'ha: delayMs = 12'h320;
      4'hb: delayMs = 12'h3e8;
      4'hc: delayMs = 12'h5dc;
      4'hd: delayMs = 12'h7d0;
      4'he: delayMs = 12'hbb8;
      4'hf: delayMs = `HPD_MAX_DELAY_MS; // R2
    endcase
  end

  // illegal configuration codes fall back to four single-ended outputs
  always_comb begin
    unique case (outputConfigType[`HPD_CFG_MODE_LSB +: 3])
      3'h0: cfgMode = hpd_pkg::CFG_DIFF;
      3'h2: cfgMode = hpd_pkg::CFG_SE_CM;
      3'h3: cfgMode = hpd_pkg::CFG_BRIDGED;
      3'h4: cfgMode = hpd_pkg::CFG_SE_BRIDGED;
      default: cfgMode = hpd_pkg::CFG_SE4;
    endcase
  end

  // paired drivers start together so a bridged or differential load sees no offset step
  always_comb begin
    drvReq = driverPower[3:0];
    drvRampEn = {4{driverGainRampControl[`HPD_RAMP_EN_BIT]}};
    unique case (cfgMode)
      hpd_pkg::CFG_DIFF, hpd_pkg::CFG_BRIDGED: begin
        drvReq = {{2{&driverPower[3:2]}}, {2{&driverPower[1:0]}}}; // R15
      end
      hpd_pkg::CFG_SE_BRIDGED: begin
        drvReq[3:2] = {2{&driverPower[3:2]}}; // R15
      end
      hpd_pkg::CFG_SE_CM: begin
        drvRampEn[3:2] = 2'h0; // R15
      end
      hpd_pkg::CFG_SE4: begin
      end
    endcase
  end

  assign drvLevel[0] = driverLevel01[3:0];
  assign drvLevel[1] = driverLevel01[7:4];
  assign drvLevel[2] = driverLevel23[3:0];
  assign drvLevel[3] = driverLevel23[7:4];

  always_comb begin
    unique case (driverPowerupDelayAndIdleState[`HPD_IDLE_LSB +: 2])
      2'h1: idleMode = hpd_pkg::PIN_WEAK_CM;
      2'h2: idleMode = hpd_pkg::PIN_WEAK_HALF;
      default: idleMode = hpd_pkg::PIN_HIZ;
    endcase
  end

  for (genvar i = 0; i < 4; i++) begin : g_drv
    hpd_driver_seq u_seq (
      .clk(clk),
      .sys_rst(sys_rst),
      .msTick(msTick),
      .delayMs(delayMs),
      .stepMs(driverGainRampControl[`HPD_RAMP_STEP_LSB +: 3]),
      .rampEn(drvRampEn[i]),
      .powerReq(drvReq[i]),
      .autoShut(driverPower[`HPD_PWR_AUTO_BIT]),
      .shortNow(shortNow[i]),
      .powered(drvPowered[i]),
      .atten(drvAtten[i]),
      .shortFlag(drvShortFlag[i])
    );

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        drvStatus[i].powered <= 1'b0;
        drvStatus[i].atten <= `HPD_ATTEN_MAX;
        drvStatus[i].gain <= 4'h0;
        drvStatus[i].pinMode <= hpd_pkg::PIN_HIZ;
      end else begin
        drvStatus[i].powered <= drvPowered[i];
        drvStatus[i].atten <= drvAtten[i]; // R4
        drvStatus[i].gain <= (drvLevel[i] > `HPD_LEVEL_MAX) ? `HPD_LEVEL_MAX : drvLevel[i]; // R5
        drvStatus[i].pinMode <= drvPowered[i] ? hpd_pkg::PIN_DRIVE : idleMode; // R3
      end
    end
  end

  // direct path only on the headphone drivers, and only while they run
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      leftDirectConverterPath <= 1'b0;
      rightDirectConverterPath <= 1'b0;
      configMode <= hpd_pkg::CFG_DIFF;
    end else begin
      leftDirectConverterPath <= driverPower[`HPD_PWR_DIRL_BIT] && drvPowered[0]; // R6
      rightDirectConverterPath <= driverPower[`HPD_PWR_DIRR_BIT] && drvPowered[1]; // R6
      configMode <= cfgMode; // R1
    end
  end

  // hold is dropped on a selected input even if software left it set
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      leftInputHold <= 4'h0; // R7
      rightInputHold <= 4'h0; // R7
      microphoneBiasOutput <= hpd_pkg::BIAS_OFF;
    end else begin
      leftInputHold <= leftInputHoldControl[3:0] & ~leftInputSelected; // R8
      rightInputHold <= rightInputHoldControl[3:0] & ~rightInputSelected; // R8
      microphoneBiasOutput <= hpd_pkg::hpd_bias_e'(micBiasControl[`HPD_BIAS_LSB +: 2]); // R9
    end
  end

  // classification; ac-coupled outputs cannot tell mono from stereo
  always_comb begin
    if (!plugNow) begin
      rawType = hpd_pkg::HS_NONE;
    end else if (micNow) begin
      rawType = hpd_pkg::HS_HEADSET; // R12
    end else if (monoNow && !outputConfigType[`HPD_CFG_AC_BIT]) begin
      rawType = hpd_pkg::HS_MONO; // R13
    end else begin
      rawType = hpd_pkg::HS_STEREO; // R13
    end
  end

  // a type must stay put for the debounce time in ms before it is reported
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      candType <= hpd_pkg::HS_NONE;
      headsetType <= hpd_pkg::HS_NONE;
      debCnt <= 3'h0;
    end else if (!jackDetectConfigA[`HPD_JACK_EN_BIT]) begin
      candType <= hpd_pkg::HS_NONE;
      headsetType <= hpd_pkg::HS_NONE;
      debCnt <= 3'h0;
    end else if (rawType != candType) begin
      candType <= rawType;
      debCnt <= 3'h0;
    end else if (debCnt >= jackDetectConfigA[`HPD_JACK_DEB_LSB +: 3]) begin
      headsetType <= candType; // R12
    end else if (msTick) begin
      debCnt <= debCnt + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/hpd_sync2.sv ----
`default_nettype none
module hpd_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // stage1 feeds only the second flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// ---- shared/hpd_consts.svh ----
`ifndef HPD_CONSTS_SVH
`define HPD_CONSTS_SVH

// register offsets
`define HPD_ADDR_HS_RESULT 7'h0d
`define HPD_ADDR_OUT_CFG 7'h0e
`define HPD_ADDR_HOLD_L 7'h14
`define HPD_ADDR_HOLD_R 7'h17
`define HPD_ADDR_MIC_BIAS 7'h19
`define HPD_ADDR_RAMP 7'h28
`define HPD_ADDR_DELAY_IDLE 7'h2a
`define HPD_ADDR_LEVEL_01 7'h33
`define HPD_ADDR_LEVEL_23 7'h34
`define HPD_ADDR_POWER 7'h35
`define HPD_ADDR_SHORT 7'h5f
`define HPD_ADDR_JACK_A 7'h60
`define HPD_ADDR_JACK_B 7'h61

// reset values
`define HPD_RST_ZERO 8'h00
`define HPD_RST_RAMP 8'h01

// field positions
`define HPD_CFG_MODE_LSB 0
`define HPD_CFG_AC_BIT 3
`define HPD_BIAS_LSB 6
`define HPD_RAMP_EN_BIT 0
`define HPD_RAMP_STEP_LSB 1
`define HPD_IDLE_LSB 0
`define HPD_DELAY_LSB 4
`define HPD_PWR_AUTO_BIT 4
`define HPD_PWR_DIRL_BIT 5
`define HPD_PWR_DIRR_BIT 6
`define HPD_JACK_EN_BIT 7
`define HPD_JACK_DEB_LSB 0
`define HPD_JACKB_PLUG_INV 0
`define HPD_JACKB_MIC_INV 1
`define HPD_JACKB_MONO_INV 2

// timing and limits
`define HPD_CLK_NS 40
`define HPD_MS_NS 1000000
`define HPD_MAX_DELAY_MS 12'hfa0
`define HPD_ATTEN_MAX 6'h3f
`define HPD_LEVEL_MAX 4'h9

`endif

// ---- shared/hpd_pkg.sv ----
`default_nettype none
package hpd_pkg;
  typedef enum logic [2:0] {
    CFG_DIFF = 3'h0,
    CFG_SE4 = 3'h1,
    CFG_SE_CM = 3'h2,
    CFG_BRIDGED = 3'h3,
    CFG_SE_BRIDGED = 3'h4
  } hpd_cfg_e;

  typedef enum logic [1:0] {
    PIN_HIZ = 2'h0,
    PIN_WEAK_CM = 2'h1,
    PIN_WEAK_HALF = 2'h2,
    PIN_DRIVE = 2'h3
  } hpd_pin_e;

  typedef enum logic [1:0] {
    BIAS_OFF = 2'h0,
    BIAS_2V0 = 2'h1,
    BIAS_2V5 = 2'h2,
    BIAS_SUPPLY = 2'h3
  } hpd_bias_e;

  typedef enum logic [1:0] {
    HS_NONE = 2'h0,
    HS_STEREO = 2'h1,
    HS_MONO = 2'h2,
    HS_HEADSET = 2'h3
  } hpd_hs_e;

  typedef enum logic [1:0] {
    DRV_OFF = 2'h0,
    DRV_DELAY = 2'h1,
    DRV_RAMP = 2'h3,
    DRV_ON = 2'h2
  } hpd_drv_state_e;

  typedef struct packed {
    logic powered;
    logic [5:0] atten;
    logic [3:0] gain;
    hpd_pin_e pinMode;
  } hpd_drv_s;
endpackage
`default_nettype wire

// ---- verification/hpd_jack_load.sv ----
`default_nettype none
module hpd_jack_load (
  // scenario controls
  input wire logic plugged,
  input wire logic hasMic,
  input wire logic isMono,
  input wire logic [3:0] shortMask,
  // driver state
  input wire hpd_pkg::hpd_drv_s [3:0] drvStatus,
  // sense lines
  output logic [3:0] shortSense,
  output logic plugSense,
  output logic micSense,
  output logic monoSense
);
  timeunit 1ns;
  timeprecision 1ns;
  // a short draws current only while the stage drives, so shutdown clears it
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      shortSense[i] = shortMask[i] && drvStatus[i].pinMode == hpd_pkg::PIN_DRIVE;
    end
  end
  assign plugSense = plugged;
  // contacts beyond the sleeve only exist with a plug in
  assign micSense = plugged && hasMic;
  assign monoSense = plugged && isMono;
endmodule
`default_nettype wire

// ---- verification/hpd_power_detect_sva.sv ----
`default_nettype none
module hpd_power_detect_sva #(
  parameter int MS_CYCLES = 25000
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic regWrite,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  // sense and selection
  input wire logic [3:0] shortSense,
  input wire logic [3:0] leftInputSelected,
  input wire logic [3:0] rightInputSelected,
  // controls
  input wire hpd_pkg::hpd_drv_s [3:0] drvStatus,
  input wire logic leftDirectConverterPath,
  input wire logic [3:0] leftInputHold,
  input wire logic [3:0] rightInputHold,
  input wire hpd_pkg::hpd_bias_e microphoneBiasOutput
);
  logic rampOn;
  logic autoOn;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // shadows of two enables, as the checker cannot read the register file
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rampOn <= 1'b1;
    else if (regWrite && regAddr == 7'h28) rampOn <= regWdata[0];
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) autoOn <= 1'b0;
    else if (regWrite && regAddr == 7'h35) autoOn <= regWdata[4];
  end
  AST_BIAS_SET: assert property (regWrite && regAddr == 7'h19 |-> ##2
    microphoneBiasOutput == $past(regWdata[7:6], 2)) else $error("bias output ignores its field");
  AST_DIRECT_PATH: assert property (regWrite && regAddr == 7'h35 |-> ##2
    leftDirectConverterPath == ($past(regWdata[5], 2) && drvStatus[0].powered))
    else $error("direct path ignores its bit");
  AST_HOLD_MASK: assert property ($stable(leftInputSelected) && $stable(rightInputSelected) |->
    (leftInputHold & leftInputSelected) == 4'h0 && (rightInputHold & rightInputSelected) == 4'h0)
    else $error("hold active on a selected input");
  AST_RESET_QUIET: assert property ($fell(sys_rst) |-> leftInputHold == 4'h0 &&
    rightInputHold == 4'h0 && drvStatus[0].pinMode == hpd_pkg::PIN_HIZ) else $error("pins not quiet after reset");
  AST_IDLE_PIN: assert property (!drvStatus[0].powered |->
    drvStatus[0].pinMode != hpd_pkg::PIN_DRIVE) else $error("pin driven while powered down");
  AST_RAMP_START: assert property ($rose(drvStatus[0].powered) && rampOn |->
    drvStatus[0].atten >= 6'h3e) else $error("ramp did not start attenuated");
  AST_LEVEL_CAP: assert property (drvStatus[0].gain <= 4'h9 && drvStatus[1].gain <= 4'h9)
    else $error("level above nine");
  AST_AUTO_OFF: assert property (autoOn && shortSense[0] |-> ##[1:6]
    !drvStatus[0].powered) else $error("shorted driver kept on");
  cover property ($rose(drvStatus[0].powered));
  cover property ($fell(drvStatus[0].powered) && autoOn);
  cover property (regWrite && regAddr == 7'h19);
endmodule
bind hpd_power_detect hpd_power_detect_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (
  .clk(clk), .sys_rst(sys_rst), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
  .shortSense(shortSense), .leftInputSelected(leftInputSelected), .rightInputSelected(rightInputSelected),
  .drvStatus(drvStatus), .leftDirectConverterPath(leftDirectConverterPath), .leftInputHold(leftInputHold),
  .rightInputHold(rightInputHold), .microphoneBiasOutput(microphoneBiasOutput)
);
`default_nettype wire

// ---- verification/hpd_power_detect_test.sv ----
`default_nettype none
module hpd_power_detect_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 10;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [6:0] regAddr = 7'h00;
  logic [7:0] regWdata = 8'h00;
  logic [3:0] leftSel = 4'h0;
  logic [3:0] rightSel = 4'h0;
  logic plugged = 1'b0;
  logic hasMic = 1'b0;
  logic isMono = 1'b0;
  logic [3:0] shortMask = 4'h0;
  logic [7:0] regRdata;
  logic [3:0] shortSense, leftHold, rightHold, sel;
  logic plugSense, micSense, monoSense, leftDirect, rightDirect;
  hpd_pkg::hpd_drv_s [3:0] drvStatus;
  hpd_pkg::hpd_cfg_e configMode;
  hpd_pkg::hpd_bias_e bias;
  int num_errors = 0;
  int checks_done = 0;
  int n0, n2, i;
  int expType[$] = '{0, 1, 2, 3, 1};
  logic [1:0] idleExp[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  hpd_power_detect #(.MS_CYCLES(MS)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .shortSense(shortSense), .plugSense(plugSense),
    .micSense(micSense), .monoSense(monoSense), .leftInputSelected(leftSel), .rightInputSelected(rightSel),
    .drvStatus(drvStatus), .leftDirectConverterPath(leftDirect), .rightDirectConverterPath(rightDirect),
    .configMode(configMode), .leftInputHold(leftHold), .rightInputHold(rightHold), .microphoneBiasOutput(bias)
  );
  hpd_jack_load u_load (
    .plugged(plugged), .hasMic(hasMic), .isMono(isMono), .shortMask(shortMask), .drvStatus(drvStatus),
    .shortSense(shortSense), .plugSense(plugSense), .micSense(micSense), .monoSense(monoSense)
  );
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chkv(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chkv(regRdata & m, e);
  endtask
  // bounded so a driver that never moves ends as a mismatch, not a hang
  task automatic waitpw(input logic v, output int n);
    n = 0;
    while (drvStatus[0].powered !== v && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chkv({7'h0, drvStatus[0].powered}, {7'h0, v});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    settle(20000);
    num_errors++;
    complete_run;
  end
  initial begin
    n0 = $urandom(91);
    settle(20);
    sys_rst <= 1'b0;
    settle(1);
    rdchk(7'h28, 8'h01, 8'hff);
    rdchk(7'h5f, 8'h00, 8'hff);
    rdchk(7'h7e, 8'h00, 8'hff);
    chkv({leftHold, rightHold}, 8'h00);
    for (i = 0; i < 5; i++) begin
      wr(7'h0e, 8'(i));
      chkv(8'(configMode), 8'(i));
    end
    for (i = 0; i < 4; i++) begin
      wr(7'h19, 8'(i << 6));
      chkv(8'(bias), 8'(i));
    end
    for (i = 0; i < 4; i++) begin
      sel = 4'($urandom);
      leftSel <= sel;
      rightSel <= ~sel;
      wr(7'h14, 8'h0f);
      wr(7'h17, 8'h0f);
      chkv({leftHold, rightHold}, {~sel, sel});
    end
    for (i = 1; i < 4; i++) begin
      wr(7'h35, 8'(i << 5) | 8'h03);
      settle(2);
      chkv({6'h0, rightDirect, leftDirect}, 8'(i));
    end
    wr(7'h35, 8'h00);
    wr(7'h0e, 8'h00);
    wr(7'h35, 8'h01);
    settle(8);
    chkv({7'h0, drvStatus[0].powered}, 8'h00);
    wr(7'h35, 8'h00);
    wr(7'h0e, 8'h01);
    for (i = 0; i < 4; i++) begin
      wr(7'h2a, 8'(i));
      chkv({6'h0, drvStatus[0].pinMode}, {6'h0, idleExp[i]});
    end
    wr(7'h33, 8'hc5);
    wr(7'h28, 8'h00);
    wr(7'h2a, 8'h01);
    wr(7'h35, 8'h03);
    waitpw(1'b1, n0);
    chkv({drvStatus[1].gain, drvStatus[0].gain}, 8'h95);
    chkv({6'h0, drvStatus[0].pinMode}, 8'h03);
    wr(7'h35, 8'h00);
    waitpw(1'b0, n2);
    wr(7'h2a, 8'h21);
    wr(7'h35, 8'h03);
    waitpw(1'b1, n2);
    chkv(8'(n2 >= n0 + MS && n2 <= n0 + 2 * MS + 2), 8'h01);
    wr(7'h35, 8'h00);
    waitpw(1'b0, n2);
    wr(7'h2a, 8'h01);
    wr(7'h28, 8'h01);
    wr(7'h35, 8'h01);
    waitpw(1'b1, n0);
    chkv(8'(drvStatus[0].atten >= 6'h3e), 8'h01);
    n2 = 0;
    while (drvStatus[0].atten !== 6'h00 && n2 < 2000) begin
      settle(1);
      n2++;
    end
    chkv(8'(n2 >= 62 * MS && n2 <= 64 * MS + 4), 8'h01);
    shortMask <= 4'h1;
    settle(10);
    chkv({7'h0, drvStatus[0].powered}, 8'h01);
    rdchk(7'h5f, 8'h01, 8'h0f);
    wr(7'h35, 8'h11);
    settle(10);
    chkv({7'h0, drvStatus[0].powered}, 8'h00);
    rdchk(7'h5f, 8'h10, 8'hf0);
    shortMask <= 4'h0;
    wr(7'h35, 8'h11);
    settle(30);
    chkv({7'h0, drvStatus[0].powered}, 8'h00);
    wr(7'h35, 8'h10);
    wr(7'h35, 8'h11);
    waitpw(1'b1, n0);
    rdchk(7'h5f, 8'h00, 8'hf0);
    wr(7'h19, 8'hc0);
    wr(7'h60, 8'h80);
    foreach (expType[k]) begin
      plugged <= k > 0;
      hasMic <= k == 3;
      isMono <= k == 2 || k == 4;
      wr(7'h0e, k == 4 ? 8'h09 : 8'h01);
      settle(20);
      rdchk(7'h0d, {k > 0, 1'b0, 2'(expType[k]), 4'h0}, 8'hb0);
    end
    complete_run;
  end
endmodule
`default_nettype wire
